// ===== verilog/spinv_access.sv
// Purpose: command logic of a serial nonvolatile byte memory on a spi slave port
// Assumes: clk at 100 MHz, sck half period of at least 4 clk cycles
// Notes:   pins are oversampled; guard bits hold their value across rst_n
`timescale 1ns/10ps
`default_nettype none
`include "spinv_defines.svh"

// small fifo between the serial receiver and the array write port
module spinv_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = `SPINV_FIFO_DEPTH
) (
  input  wire logic             clk,       // system clock
  input  wire logic             rst_n,     // async reset, active low
  input  wire logic [WIDTH-1:0] in_data,   // word to store
  input  wire logic             in_valid,  // word offered
  output logic                  in_ready,  // room left
  output logic      [WIDTH-1:0] out_data,  // oldest word
  output logic                  out_valid, // fifo not empty
  input  wire logic             out_ready  // drain side takes the word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] buf_q [0:DEPTH-1]; // storage, no reset needed
  logic [AW:0]      wr_ptr_q;          // write pointer with wrap bit
  logic [AW:0]      rd_ptr_q;          // read pointer with wrap bit
  logic [AW:0]      used;              // words held

  assign used      = wr_ptr_q - rd_ptr_q;
  assign in_ready  = (used != DEPTH[AW:0]);
  assign out_valid = (used != '0);
  assign out_data  = buf_q[rd_ptr_q[AW-1:0]];

  // storage write
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      buf_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // pointers; extra bit tells full from empty
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  // a word taken into an empty fifo must show at the drain side next cycle
  AST_FIFO_SHOWS_WORD: assert property (@(posedge clk) disable iff (!rst_n)
    (in_valid && in_ready && !out_valid) |=> (out_valid && out_data == $past(in_data)))
    else $error("fifo lost a word taken while empty");
endmodule

module spinv_access
  import spinv_pkg::*;
(
  input  wire logic        clk,      // system clock, 100 MHz
  input  wire logic        rst_n,    // async reset, active low
  input  wire spinv_pkg::spinv_pins_t pins, // cs_n, sck, si, wp_n from the pins
  output logic             so_q,     // serial output level
  output logic             so_oe_q   // serial output enable, high while driven
);
  import spinv_pkg::*;

  localparam spinv_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};

  spinv_pins_t              s1_q;          // first sampling stage
  spinv_pins_t              s2_q;          // second sampling stage
  spinv_pins_t              s3_q;          // third sampling stage
  spinv_pins_t              filt_q;        // accepted pin levels
  logic                     sck_prev_q;    // previous accepted sck
  logic                     cs_prev_q;     // previous accepted cs_n
  spinv_state_t             st_q;          // protocol state
  logic [2:0]               bit_cnt_q;     // bit within byte
  logic [1:0]               byte_cnt_q;    // address byte index
  logic [7:0]               sh_q;          // receive shifter
  logic [7:0]               op_q;          // opcode of this frame
  logic [7:0]               tx_q;          // transmit shifter
  logic [`SPINV_ADDR_W-1:0] addr_q;        // burst address counter
  logic                     stop_q;        // write burst halted
  logic                     clr_pend_q;    // latch clears at frame end
  logic                     latch_q;       // write enable latch
  logic [1:0]               ld_q;          // transmit load pipeline
  logic                     wr_pend_q;     // byte waiting for fifo room
  spinv_wr_t                wr_req_q;      // byte waiting for fifo room
  logic [7:0]               rd_data_q;     // array read data
  logic                     fifo_in_ready; // fifo has room
  spinv_wr_t                fifo_out;      // oldest fifo entry
  logic                     fifo_valid;    // fifo holds an entry
  logic                     fifo_take;     // array port free for a write

  // nonvolatile guard bits: no reset, factory value at power-up only
  logic [1:0]               guard_q = `SPINV_GUARD_RST;
  logic                     pin_guard_enable_q  = `SPINV_PIN_GUARD_RST;

  // the array itself
  logic [7:0]               mem_q [0:`SPINV_MEM_DEPTH-1];

  logic                     sck_rise;      // accepted sck rising edge
  logic                     sck_fall;      // accepted sck falling edge
  logic                     cs_rise;       // accepted end of frame
  logic                     cs_fall;       // accepted start of frame
  logic                     sel;           // device selected
  logic                     byte_done;     // eighth bit of a byte taken
  logic [7:0]               byte_in;       // byte completed by this edge
  logic                     tx_start;      // a new output byte is due
  logic                     wr_ok;         // data byte may reach the array
  logic                     swr_ok;        // status write is permitted

  // status byte as read back; fixed bits are constants
  function automatic logic [7:0] status_fn(input logic pe, input logic [1:0] g,
                                           input logic l);
    logic [7:0] s;
    s                       = 8'h00;
    s[`SPINV_ST_PIN_GUARD]  = pe;
    s[`SPINV_ST_FIXED_ONE]  = 1'b1;
    s[`SPINV_ST_GUARD_HIGH] = g[1];
    s[`SPINV_ST_GUARD_LOW]  = g[0];
    s[`SPINV_ST_LATCH]      = l;
    status_fn               = s;
  endfunction

  // true when the guard setting covers this address
  function automatic logic guarded(input logic [1:0] g, input logic [`SPINV_ADDR_W-1:0] a);
    case (g)
      2'h1:    guarded = (a >= `SPINV_QUARTER_BASE);
      2'h2:    guarded = (a >= `SPINV_HALF_BASE);
      2'h3:    guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction

  assign sck_rise  = filt_q.sck & ~sck_prev_q;
  assign sck_fall  = ~filt_q.sck & sck_prev_q;
  assign cs_rise   = filt_q.cs_n & ~cs_prev_q;
  assign cs_fall   = ~filt_q.cs_n & cs_prev_q;
  assign sel       = ~filt_q.cs_n;
  assign byte_in   = {sh_q[6:0], filt_q.si};
  assign byte_done = sck_rise && sel && (bit_cnt_q == 3'h7);
  // protect pin is not looked at here: it never guards the array
  assign wr_ok     = latch_q && !stop_q && !guarded(guard_q, addr_q);
  assign swr_ok    = latch_q && !(pin_guard_enable_q && !filt_q.wp_n);
  assign fifo_take = (ld_q == 2'b00);
  assign tx_start  = byte_done &&
                     ((st_q == SPINV_OPC && byte_in == `SPINV_OP_STAT_RD) ||
                      (st_q == SPINV_ADDR && byte_cnt_q == 2'h2 && op_q == `SPINV_OP_MEM_RD) ||
                      st_q == SPINV_DUMMY || st_q == SPINV_RDATA || st_q == SPINV_SRD);

  // pin sampling: a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q       <= PINS_IDLE;
      s2_q       <= PINS_IDLE;
      s3_q       <= PINS_IDLE;
      filt_q     <= PINS_IDLE;
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      s1_q       <= pins;
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      filt_q     <= (filt_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
      sck_prev_q <= filt_q.sck;
      cs_prev_q  <= filt_q.cs_n;
    end
  end

  // receive shifter; bit count restarts with each frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 3'h0;
      sh_q      <= 8'h00;
    end else if (!sel) begin
      bit_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      sh_q      <= byte_in;
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // protocol state; deselect always returns to idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= SPINV_IDLE;
      op_q       <= 8'h00;
      byte_cnt_q <= 2'h0;
    end else if (!sel) begin
      st_q       <= SPINV_IDLE;
    end else if (cs_fall) begin
      st_q       <= SPINV_OPC;
      byte_cnt_q <= 2'h0;
    end else if (byte_done) begin
      case (st_q)
        SPINV_OPC: begin
          op_q <= byte_in;
          case (byte_in)
            `SPINV_OP_STAT_RD: st_q <= SPINV_SRD;
            `SPINV_OP_STAT_WR: st_q <= SPINV_SWR;
            `SPINV_OP_MEM_RD,
            `SPINV_OP_FAST_RD,
            `SPINV_OP_MEM_WR:  st_q <= SPINV_ADDR;
            // latch commands and unknown opcodes ignore the rest of the frame
            default:           st_q <= SPINV_IGNORE;
          endcase
        end
        SPINV_ADDR: begin
          byte_cnt_q <= byte_cnt_q + 2'h1;
          if (byte_cnt_q == 2'h2) begin
            case (op_q)
              `SPINV_OP_MEM_RD:  st_q <= SPINV_RDATA;
              `SPINV_OP_FAST_RD: st_q <= SPINV_DUMMY;
              default:           st_q <= SPINV_WDATA;
            endcase
          end
        end
        SPINV_DUMMY: st_q <= SPINV_RDATA;
        SPINV_SWR:   st_q <= SPINV_IGNORE;          // one data byte only
        default:     st_q <= st_q;
      endcase
    end
  end

  // address counter; wrap comes free from the 17-bit width
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
    end else if (byte_done && st_q == SPINV_ADDR) begin
      addr_q <= `SPINV_ADDR_W'({addr_q, byte_in});
    end else if (ld_q[1] && st_q == SPINV_RDATA) begin
      addr_q <= addr_q + 1'b1;
    end else if (byte_done && st_q == SPINV_WDATA && wr_ok) begin
      addr_q <= addr_q + 1'b1;
    end
  end

  // write burst: a complete byte goes to the fifo or halts the burst
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_q    <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_req_q  <= '0;
    end else begin
      if (wr_pend_q && fifo_in_ready) begin
        wr_pend_q <= 1'b0;
      end
      if (cs_fall) begin
        stop_q <= 1'b0;
      end else if (byte_done && st_q == SPINV_WDATA) begin
        if (wr_ok) begin
          wr_pend_q <= 1'b1;
          wr_req_q  <= '{addr: addr_q, data: byte_in};
        end else begin
          stop_q <= 1'b1;
        end
      end
    end
  end

  // write enable latch; set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q    <= `SPINV_LATCH_RST;
      clr_pend_q <= 1'b0;
    end else begin
      if (byte_done && st_q == SPINV_OPC && byte_in == `SPINV_OP_SET_LATCH) begin
        latch_q <= 1'b1;
      end else if (cs_rise && clr_pend_q) begin
        latch_q <= 1'b0;
      end
      if (cs_rise || cs_fall) begin
        clr_pend_q <= 1'b0;
      end else if (byte_done && st_q == SPINV_OPC &&
                   (byte_in == `SPINV_OP_CLR_LATCH || byte_in == `SPINV_OP_STAT_WR ||
                    byte_in == `SPINV_OP_MEM_WR)) begin
        clr_pend_q <= 1'b1;
      end
    end
  end

  // guard bits: kept through rst_n so that they behave as nonvolatile
  always_ff @(posedge clk) begin
    if (byte_done && st_q == SPINV_SWR && swr_ok) begin
      pin_guard_enable_q  <= byte_in[`SPINV_ST_PIN_GUARD];
      guard_q <= {byte_in[`SPINV_ST_GUARD_HIGH], byte_in[`SPINV_ST_GUARD_LOW]};
    end
  end

  // array port: reads every cycle, writes from the fifo when no fetch is due
  always_ff @(posedge clk) begin
    rd_data_q <= mem_q[addr_q];
    if (fifo_valid && fifo_take) begin
      mem_q[fifo_out.addr] <= fifo_out.data;
    end
  end

  // fetch pipeline: two cycles from address to array data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_q <= 2'b00;
    end else if (!sel) begin
      ld_q <= 2'b00;
    end else begin
      ld_q <= {ld_q[0], tx_start};
    end
  end

  // transmit: load the next byte, shift out msb first on sck falling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q    <= 8'h00;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (!sel) begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (ld_q[1]) begin
      tx_q <= (st_q == SPINV_SRD) ? status_fn(pin_guard_enable_q, guard_q, latch_q)
                                  : rd_data_q;
    end else if (sck_fall && (st_q == SPINV_SRD || st_q == SPINV_RDATA)) begin
      so_q    <= tx_q[7];
      so_oe_q <= 1'b1;
      tx_q    <= {tx_q[6:0], 1'b0};
    end
  end

  // a byte stalls here if the fifo is full; the array side stalls on fetches
  spinv_fifo #(
    .WIDTH ($bits(spinv_wr_t)),
    .DEPTH (`SPINV_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (wr_req_q),
    .in_valid  (wr_pend_q),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_LATCH_AFTER_RESET: assert property ($rose(rst_n) |-> !latch_q)
    else $error("latch set right after reset");
  AST_SET_LATCH: assert property (
    (byte_done && st_q == SPINV_OPC && byte_in == `SPINV_OP_SET_LATCH) |=> latch_q)
    else $error("set command did not set latch");
  AST_CLEAR_AT_END: assert property ((cs_rise && clr_pend_q) |=> !latch_q)
    else $error("latch not cleared at frame end");
  AST_STATUS_LOAD: assert property (
    (ld_q[1] && st_q == SPINV_SRD) |=> (tx_q[6:4] == 3'b100 && !tx_q[0] && tx_q[1] == latch_q))
    else $error("status byte fixed bits wrong");
  AST_PIN_BLOCK: assert property (
    (byte_done && st_q == SPINV_SWR && pin_guard_enable_q && !filt_q.wp_n) |=>
    ($stable(guard_q) && $stable(pin_guard_enable_q)))
    else $error("status written while pin guard active");
  AST_NO_GUARDED_WRITE: assert property (
    (byte_done && st_q == SPINV_WDATA && guarded(guard_q, addr_q)) |=>
    (stop_q && $stable(addr_q)))
    else $error("guarded address accepted");
  AST_READ_WRAP: assert property (
    (ld_q[1] && st_q == SPINV_RDATA && addr_q == `SPINV_ADDR_LAST) |=> (addr_q == '0))
    else $error("address did not wrap");
  AST_FRAME_END: assert property (cs_rise |=> (st_q == SPINV_IDLE && !so_oe_q))
    else $error("frame end left output driven");
  AST_FAST_DUMMY: assert property (
    (byte_done && st_q == SPINV_ADDR && byte_cnt_q == 2'h2 && op_q == `SPINV_OP_FAST_RD)
    |=> (st_q == SPINV_DUMMY && ld_q == 2'b00))
    else $error("fast read skipped dummy byte");

  COV_STATUS_READ: cover property ((st_q == SPINV_SRD) ##[1:200] so_oe_q);
  COV_WRITE_BYTE:  cover property (fifo_valid && fifo_take);
  COV_FAST_READ:   cover property ((st_q == SPINV_DUMMY) ##[1:200] (st_q == SPINV_RDATA));
  COV_BURST_STOP:  cover property ($rose(stop_q));
endmodule
`default_nettype wire

// ===== verilog/spinv_defines.svh
// Purpose: constants of the serial nonvolatile byte memory command logic
// Assumes: included by bare name wherever a constant is needed
// Notes:   opcodes travel msb first; addresses are 17 bits wide
`ifndef SPINV_DEFINES_SVH
`define SPINV_DEFINES_SVH

// command opcodes
`define SPINV_OP_SET_LATCH  8'h06
`define SPINV_OP_CLR_LATCH  8'h04
`define SPINV_OP_STAT_RD    8'h05
`define SPINV_OP_STAT_WR    8'h01
`define SPINV_OP_MEM_RD     8'h03
`define SPINV_OP_FAST_RD    8'h0b
`define SPINV_OP_MEM_WR     8'h02

// status byte field positions
`define SPINV_ST_PIN_GUARD  7
`define SPINV_ST_FIXED_ONE  6
`define SPINV_ST_GUARD_HIGH 3
`define SPINV_ST_GUARD_LOW  2
`define SPINV_ST_LATCH      1

// reset and factory values
`define SPINV_GUARD_RST     2'h0
`define SPINV_PIN_GUARD_RST 1'h0
`define SPINV_LATCH_RST     1'h0

// address space and guarded bases
`define SPINV_ADDR_W        17
`define SPINV_ADDR_LAST     17'h1ffff
`define SPINV_QUARTER_BASE  17'h18000
`define SPINV_HALF_BASE     17'h10000
`define SPINV_MEM_DEPTH     131072
`define SPINV_FIFO_DEPTH    16

`endif

// ===== verilog/spinv_pkg.sv
// Purpose: types shared by the serial nonvolatile memory command logic
// Assumes: spinv_defines.svh is on the include path
// Notes:   pin bundle and write request travel as packed structs
`include "spinv_defines.svh"
`default_nettype none

package spinv_pkg;

  // protocol engine states
  typedef enum logic [3:0] {
    SPINV_IDLE,
    SPINV_OPC,
    SPINV_ADDR,
    SPINV_DUMMY,
    SPINV_RDATA,
    SPINV_WDATA,
    SPINV_SRD,
    SPINV_SWR,
    SPINV_IGNORE
  } spinv_state_t;

  // serial pins seen by the device
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } spinv_pins_t;

  // one byte bound for the array
  typedef struct packed {
    logic [`SPINV_ADDR_W-1:0] addr;
    logic [7:0]               data;
  } spinv_wr_t;

endpackage
`default_nettype wire

// ===== tb/spinv_master.sv
// Purpose: spi master model that drives the serial pins in mode 0
// Assumes: paced by clk, four clk cycles to each half period of the link
// Notes:   sck stands low outside frames; a released si shows the inverse bit
`timescale 1ns/10ps
`default_nettype none
module spinv_master (
  input  wire logic clk,  // system clock, paces the link
  output logic      cs_n, // chip select, active low
  output logic      sck,  // link clock, 80 ns period
  output logic      si,   // serial data to the device
  input  wire logic so    // resolved serial data from the device
);
  // idle levels at time zero
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // one half period; changes land just after a clk edge
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // one command per chip select low, opened by the falling edge
  task automatic start();
    half();
    cs_n = 1'b0;
  endtask
  // n bits msb first; read data is taken late in the high phase because
  // the device answers several clk cycles after the falling edge
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      half();
      sck = 1'b1;
      half();
      rx[i] = so;
      sck = 1'b0;
    end
  endtask
  // released data line shows the inverse so a stale bit is never trusted
  task automatic stop();
    half();
    cs_n = 1'b1;
    si   = ~si;
    half();
    half();
  endtask
endmodule
`default_nettype wire

// ===== tb/spi_nv_memory_protect_access_test.sv
// Purpose: self-checking bench for the serial memory command logic
// Assumes: spinv_master plays the spi master, wp_n is driven here
// Notes:   expectations come from the guard table and the status layout
`timescale 1ns/10ps
`default_nettype none
module spi_nv_memory_protect_access_test;
  import spinv_pkg::*;
  logic        clk;         // system clock
  logic        rst_n;       // reset, active low
  logic        wp_n;        // protect pin, active low
  logic        cs_n;        // from the master model
  logic        sck;         // from the master model
  logic        si;          // from the master model
  logic        so_q;        // device data out
  logic        so_oe_q;     // device data enable
  wire         so_line;     // resolved serial output
  spinv_pins_t pins;        // bundled pins
  int          n_errors;    // mismatches
  int          checks_done; // comparisons
  int          cycles;      // timeout count
  logic [7:0]  tq[$];       // bytes to send
  logic [7:0]  rq[$];       // bytes received
  logic [16:0] pa[4];       // guard probe addresses
  logic [7:0]  ex[4];       // expected probe contents
  logic        prot;        // probe guarded

  assign pins    = {cs_n, sck, si, wp_n};
  assign so_line = so_oe_q ? so_q : 1'bz;

  spinv_access i_spinv_access (.clk(clk), .rst_n(rst_n), .pins(pins), .so_q(so_q),
                               .so_oe_q(so_oe_q));
  spinv_master i_spinv_master (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line));

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one frame of tq; the last byte may be cut short to lb bits
  task automatic frame(input int lb);
    logic [7:0] r;
    rq = {};
    i_spinv_master.start();
    foreach (tq[i]) begin
      i_spinv_master.xfer(tq[i], (i == tq.size() - 1) ? lb : 8, r);
      rq.push_back(r);
    end
    i_spinv_master.stop();
    chk8("output enable idle", 8'h00, {7'h00, so_oe_q});
  endtask

  task automatic op1(input logic [7:0] op);
    tq = {op};
    frame(8);
  endtask

  task automatic stchk(input logic [7:0] exp);
    tq = {8'h05, 8'h00};
    frame(8);
    chk8("status", exp, rq[1]);
  endtask

  // latch first in its own frame, then the status byte
  task automatic stw(input logic [7:0] v);
    op1(8'h06);
    tq = {8'h01, v};
    frame(8);
  endtask

  task automatic mwr(input logic [23:0] a, input logic [7:0] d[$], input bit en, input int lb);
    if (en)
      op1(8'h06);
    tq = {8'h02, a[23:16], a[15:8], a[7:0], d};
    frame(lb);
  endtask

  // si carries a busy pattern during data bytes, which must be ignored
  task automatic mrd(input logic [23:0] a, input bit fast, input logic [7:0] e[$]);
    tq = {fast ? 8'h0b : 8'h03, a[23:16], a[15:8], a[7:0]};
    if (fast)
      tq.push_back(8'ha5);
    foreach (e[i])
      tq.push_back(8'h5a);
    frame(8);
    foreach (e[i])
      chk8("read data", e[i], rq[rq.size() - e.size() + i]);
  endtask

  // free running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well above the roughly 22k cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    rst_n = 1'b0;
    wp_n  = 1'b1;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    pa = '{17'h0ffff, 17'h10000, 17'h17fff, 17'h18000};
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (12) @(posedge clk);
    stchk(8'h40);
    op1(8'h06);
    stchk(8'h42);
    op1(8'h04);
    stchk(8'h40);
    tq = {8'h06, 8'h01, 8'hff};
    frame(8);
    stchk(8'h42);
    // every guard setting against both sides of each boundary
    for (int g = 0; g < 4; g++) begin
      stw({4'h0, g[1:0], 2'b00});
      stchk({4'h4, g[1:0], 2'b00});
      for (int p = 0; p < 4; p++) begin
        prot = (g == 3) || (g == 2 && pa[p] >= 17'h10000) || (g == 1 && pa[p] >= 17'h18000);
        mwr({7'h00, pa[p]}, {8'(g * 16 + p)}, 1'b1, 8);
        if (!prot)
          ex[p] = 8'(g * 16 + p);
        mrd({7'h00, pa[p]}, 1'b0, {ex[p]});
      end
    end
    stw(8'h00);
    mwr(24'h000020, {8'h77, 8'h88}, 1'b1, 8);
    mwr(24'h000020, {8'hc3}, 1'b0, 8);
    mrd(24'h000020, 1'b0, {8'h77, 8'h88});
    mwr(24'h000020, {8'hc1, 8'hff}, 1'b1, 5);
    mrd(24'h000020, 1'b0, {8'hc1, 8'h88});
    stchk(8'h40);
    mwr(24'h017ffe, {8'h01, 8'h02, 8'h03, 8'h04}, 1'b1, 8);
    stw(8'hff);
    stchk(8'hcc);
    wp_n = 1'b0;
    stw(8'h84);
    stchk(8'hcc);
    wp_n = 1'b1;
    stw(8'h84);
    stchk(8'hc4);
    wp_n = 1'b0;
    mwr(24'h017ffe, {8'ha1, 8'ha2, 8'ha3, 8'ha4}, 1'b1, 8);
    mrd(24'h017ffe, 1'b0, {8'ha1, 8'ha2, 8'h03, 8'h04});
    wp_n = 1'b1;
    stw(8'h00);
    wp_n = 1'b0;
    stw(8'h08);
    stchk(8'h48);
    stw(8'h00);
    wp_n = 1'b1;
    mwr(24'hffffff, {8'h5a, 8'h5b}, 1'b1, 8);
    mrd(24'h01ffff, 1'b1, {8'h5a, 8'h5b});
    mrd(24'h000000, 1'b0, {8'h5b});
    close_out();
  end
endmodule
`default_nettype wire
